// *** logic/mesf_event_status_flags.v ***
// Sticky event status flags register with its internal register port
`timescale 1ns/1ns
`default_nettype none
`include "mesf_map.vh"

module mesf_event_status_flags (
	// Clock and reset
	input  wire                              CORE_CLK_IN,
	input  wire                              NRST_IN,
	// Internal register port from the serial interface
	input  wire [`MESF_ADDR_WIDTH-1:0]       REG_ADDR_IN,
	input  wire                              REG_WR_IN,
	input  wire                              REG_RD_IN,
	input  wire [`MESF_DATA_WIDTH-1:0]       REG_WDATA_IN,
	output reg  [`MESF_DATA_WIDTH-1:0]       REG_RDATA_OUT,
	output reg                               REG_RVALID_OUT,
	// Checksum engine events
	input  wire                              CHECKSUM_DONE_IN,
	input  wire                              CHECKSUM_CHANGED_IN,
	input  wire [`MESF_DATA_WIDTH-1:0]       CHECKSUM_VALUE_IN,
	output reg  [`MESF_DATA_WIDTH-1:0]       CHECKSUM_RESULT_REGISTER_OUT,
	// Dip and swell events, bit 2 = C, 1 = B, 0 = A
	input  wire [`MESF_PHASE_WIDTH-1:0]      SAG_CHANGE_IN,
	input  wire [`MESF_PHASE_WIDTH-1:0]      OVERVOLTAGE_CHANGE_IN,
	// Sequence, overcurrent and power-up events
	input  wire                              PHASE_ORDER_ERROR_IN,
	input  wire [`MESF_PHASE_WIDTH-1:0]      OVERCURRENT_PHASE_IN,
	output reg  [`MESF_PHASE_WIDTH-1:0]      OVERCURRENT_PHASE_REGISTER_OUT,
	input  wire                              POWERUP_DONE_IN,
	input  wire                              LOWEST_POWER_MODE_IN,
	// Zero crossing events, bit 2 = C, 1 = B, 0 = A
	input  wire [`MESF_PHASE_WIDTH-1:0]      CURRENT_CROSSING_IN,
	input  wire                              COMBINED_CROSSING_IN,
	input  wire [`MESF_PHASE_WIDTH-1:0]      VOLTAGE_CROSSING_IN,
	input  wire [`MESF_PHASE_WIDTH-1:0]      CROSSING_TIMEOUT_IN,
	// Fundamental apparent no-load state per phase
	input  wire [`MESF_PHASE_WIDTH-1:0]      FUND_APPARENT_IDLE_IN,
	output reg  [`MESF_PHASE_WIDTH-1:0]      IDLE_PHASE_REGISTER_OUT,
	// Flag register contents
	output reg  [`MESF_DATA_WIDTH-1:0]       EVENT_STATUS_FLAGS_ONE_OUT
);

	wire                          hit;
	wire                          wr_hit;
	reg  [`MESF_DATA_WIDTH-1:0]   next_set;
	wire [`MESF_DATA_WIDTH-1:0]   flags;
	reg                           was_low_power;
	reg                           powerup_armed;
	wire                          powerup_event;
	reg  [`MESF_PHASE_WIDTH-1:0]  idle_prev;
	wire                          idle_change;
	reg                           idle_primed;

	// Register decode
	assign hit    = (REG_ADDR_IN == `MESF_ADDR_EVENT_STATUS_FLAGS_ONE);
	assign wr_hit = hit & REG_WR_IN;

	// Power-up done counts once after reset and after each exit of lowest power mode
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			was_low_power <= 1'b0;
			powerup_armed <= 1'b1;
		end else begin
			was_low_power <= LOWEST_POWER_MODE_IN;
			if (was_low_power && !LOWEST_POWER_MODE_IN) begin
				powerup_armed <= 1'b1;
			end else if (POWERUP_DONE_IN) begin
				powerup_armed <= 1'b0;
			end
		end
	end

	assign powerup_event = POWERUP_DONE_IN & powerup_armed & ~LOWEST_POWER_MODE_IN;

	// No-load state tracking, change of any phase raises an event
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			idle_prev   <= {`MESF_PHASE_WIDTH{1'b0}};
			idle_primed <= 1'b0;
		end else begin
			idle_prev   <= FUND_APPARENT_IDLE_IN;
			idle_primed <= 1'b1;
		end
	end

	assign idle_change = idle_primed & (idle_prev != FUND_APPARENT_IDLE_IN);

	// Per-bit set requests
	always @* begin
		next_set = `MESF_FLAGS_RESET;
		next_set[`MESF_BIT_CHECKSUM_DONE]      = CHECKSUM_DONE_IN;
		next_set[`MESF_BIT_CHECKSUM_CHANGED]   = CHECKSUM_CHANGED_IN;
		next_set[`MESF_BIT_SAG_C]              = SAG_CHANGE_IN[2];
		next_set[`MESF_BIT_SAG_B]              = SAG_CHANGE_IN[1];
		next_set[`MESF_BIT_SAG_A]              = SAG_CHANGE_IN[0];
		next_set[`MESF_BIT_OVERVOLTAGE_C]      = OVERVOLTAGE_CHANGE_IN[2];
		next_set[`MESF_BIT_OVERVOLTAGE_B]      = OVERVOLTAGE_CHANGE_IN[1];
		next_set[`MESF_BIT_OVERVOLTAGE_A]      = OVERVOLTAGE_CHANGE_IN[0];
		next_set[`MESF_BIT_PHASE_ORDER_ERROR]  = PHASE_ORDER_ERROR_IN;
		next_set[`MESF_BIT_OVERCURRENT]        = |OVERCURRENT_PHASE_IN;
		next_set[`MESF_BIT_POWERUP_COMPLETE]   = powerup_event;
		next_set[`MESF_BIT_CURRENT_CROSSING_C] = CURRENT_CROSSING_IN[2];
		next_set[`MESF_BIT_CURRENT_CROSSING_B] = CURRENT_CROSSING_IN[1];
		next_set[`MESF_BIT_CURRENT_CROSSING_A] = CURRENT_CROSSING_IN[0];
		next_set[`MESF_BIT_COMBINED_CROSSING]  = COMBINED_CROSSING_IN;
		next_set[`MESF_BIT_VOLTAGE_CROSSING_C] = VOLTAGE_CROSSING_IN[2];
		next_set[`MESF_BIT_VOLTAGE_CROSSING_B] = VOLTAGE_CROSSING_IN[1];
		next_set[`MESF_BIT_VOLTAGE_CROSSING_A] = VOLTAGE_CROSSING_IN[0];
		next_set[`MESF_BIT_CROSSING_TIMEOUT_C] = CROSSING_TIMEOUT_IN[2];
		next_set[`MESF_BIT_CROSSING_TIMEOUT_B] = CROSSING_TIMEOUT_IN[1];
		next_set[`MESF_BIT_CROSSING_TIMEOUT_A] = CROSSING_TIMEOUT_IN[0];
		next_set[`MESF_BIT_FUND_APPARENT_IDLE] = idle_change;
	end

	// One sticky cell per implemented flag; reserved and unused bits stay zero
	genvar gi;
	generate
		for (gi = 0; gi < `MESF_DATA_WIDTH; gi = gi + 1) begin : g_flag
			if ((gi >= `MESF_FLAG_LSB) && (gi <= `MESF_FLAG_MSB) && (gi != `MESF_BIT_RESERVED)) begin : g_cell
				mesf_flag_cell u_cell (
					.clk_in   (CORE_CLK_IN),
					.nrst_in  (NRST_IN),
					.set_in   (next_set[gi]),
					.clear_in (wr_hit & REG_WDATA_IN[gi]),
					.flag_out (flags[gi])
				);
			end else begin : g_zero
				assign flags[gi] = 1'b0;
			end
		end
	endgenerate

	// Registered copies of flags and phase registers
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			EVENT_STATUS_FLAGS_ONE_OUT     <= `MESF_FLAGS_RESET;
			CHECKSUM_RESULT_REGISTER_OUT   <= {`MESF_DATA_WIDTH{1'b0}};
			OVERCURRENT_PHASE_REGISTER_OUT <= {`MESF_PHASE_WIDTH{1'b0}};
			IDLE_PHASE_REGISTER_OUT        <= {`MESF_PHASE_WIDTH{1'b0}};
		end else begin
			EVENT_STATUS_FLAGS_ONE_OUT <= flags & `MESF_IMPLEMENTED_MASK;
			if (CHECKSUM_CHANGED_IN || CHECKSUM_DONE_IN) begin
				CHECKSUM_RESULT_REGISTER_OUT <= CHECKSUM_VALUE_IN;
			end
			if (|OVERCURRENT_PHASE_IN) begin
				OVERCURRENT_PHASE_REGISTER_OUT <= OVERCURRENT_PHASE_IN;
			end
			IDLE_PHASE_REGISTER_OUT <= FUND_APPARENT_IDLE_IN;
		end
	end

	// Read port, one cycle latency, unmapped reads return zero
	always @(posedge CORE_CLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			REG_RDATA_OUT  <= {`MESF_DATA_WIDTH{1'b0}};
			REG_RVALID_OUT <= 1'b0;
		end else begin
			REG_RVALID_OUT <= REG_RD_IN;
			if (REG_RD_IN && hit) begin
				REG_RDATA_OUT <= flags & `MESF_IMPLEMENTED_MASK;
			end else begin
				REG_RDATA_OUT <= {`MESF_DATA_WIDTH{1'b0}};
			end
		end
	end

endmodule

`default_nettype wire

// *** logic/mesf_map.vh ***
// Field positions, offsets and reset values of the event status flags register
`ifndef MESF_MAP_VH
`define MESF_MAP_VH

// Register address (word address on the internal register port)
`define MESF_ADDR_EVENT_STATUS_FLAGS_ONE 16'h0403
`define MESF_ADDR_WIDTH                  16
`define MESF_DATA_WIDTH                  32

// Flag field positions
`define MESF_BIT_CHECKSUM_DONE           27
`define MESF_BIT_CHECKSUM_CHANGED        26
`define MESF_BIT_SAG_C                   25
`define MESF_BIT_SAG_B                   24
`define MESF_BIT_SAG_A                   23
`define MESF_BIT_OVERVOLTAGE_C           22
`define MESF_BIT_OVERVOLTAGE_B           21
`define MESF_BIT_OVERVOLTAGE_A           20
`define MESF_BIT_RESERVED                19
`define MESF_BIT_PHASE_ORDER_ERROR       18
`define MESF_BIT_OVERCURRENT             17
`define MESF_BIT_POWERUP_COMPLETE        16
`define MESF_BIT_CURRENT_CROSSING_C      15
`define MESF_BIT_CURRENT_CROSSING_B      14
`define MESF_BIT_CURRENT_CROSSING_A      13
`define MESF_BIT_COMBINED_CROSSING       12
`define MESF_BIT_VOLTAGE_CROSSING_C      11
`define MESF_BIT_VOLTAGE_CROSSING_B      10
`define MESF_BIT_VOLTAGE_CROSSING_A      9
`define MESF_BIT_CROSSING_TIMEOUT_C      8
`define MESF_BIT_CROSSING_TIMEOUT_B      7
`define MESF_BIT_CROSSING_TIMEOUT_A      6
`define MESF_BIT_FUND_APPARENT_IDLE      5

// Flag span handled by this block
`define MESF_FLAG_LSB                    5
`define MESF_FLAG_MSB                    27
`define MESF_FLAG_COUNT                  23

// Mask of bits that may ever read as one (27..20, 18..5)
`define MESF_IMPLEMENTED_MASK            32'h0FF7FFE0
`define MESF_FLAGS_RESET                 32'h00000000

// Phase register widths
`define MESF_PHASE_WIDTH                 3

`endif

// *** logic/mesf_flag_cell.v ***
// One sticky write-one-to-clear event flag
`timescale 1ns/1ns
`default_nettype none

module mesf_flag_cell (
	// Clock and reset
	input  wire clk_in,
	input  wire nrst_in,
	// Event and clear
	input  wire set_in,
	input  wire clear_in,
	// Flag value
	output reg  flag_out
);

	// Set beats clear in the same cycle so no event is lost
	always @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flag_out <= 1'b0;
		end else if (set_in) begin
			flag_out <= 1'b1;
		end else if (clear_in) begin
			flag_out <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// *** bench/mesf_props.sv ***
// Concurrent checks on the event status flags register ports
`timescale 1ns/1ns
`default_nettype none
`include "mesf_map.vh"

module mesf_props (
	// Clock and reset
	input wire logic                         CORE_CLK_IN,
	input wire logic                         NRST_IN,
	// Register port
	input wire logic [`MESF_ADDR_WIDTH-1:0]  REG_ADDR_IN,
	input wire logic                         REG_WR_IN,
	input wire logic                         REG_RD_IN,
	input wire logic [`MESF_DATA_WIDTH-1:0]  REG_WDATA_IN,
	input wire logic [`MESF_DATA_WIDTH-1:0]  REG_RDATA_OUT,
	input wire logic                         REG_RVALID_OUT,
	// Events and flags
	input wire logic [`MESF_PHASE_WIDTH-1:0] SAG_CHANGE_IN,
	input wire logic [`MESF_PHASE_WIDTH-1:0] OVERCURRENT_PHASE_IN,
	input wire logic [`MESF_PHASE_WIDTH-1:0] OVERCURRENT_PHASE_REGISTER_OUT,
	input wire logic [`MESF_DATA_WIDTH-1:0]  EVENT_STATUS_FLAGS_ONE_OUT
);
	// Address decode shared by the register checks
	wire logic hit = REG_ADDR_IN == `MESF_ADDR_EVENT_STATUS_FLAGS_ONE;
	default clocking cb @(posedge CORE_CLK_IN); endclocking
	default disable iff (!NRST_IN);
	AST_RVALID: assert property (REG_RD_IN |=> REG_RVALID_OUT) else $error("read without valid");
	AST_READ: assert property (REG_RD_IN && hit |=> REG_RDATA_OUT == EVENT_STATUS_FLAGS_ONE_OUT)
		else $error("read data differs from flags");
	AST_UNMAPPED: assert property (REG_RD_IN && !hit |=> REG_RDATA_OUT == 32'h0) else $error("unmapped read");
	AST_RESERVED: assert property ((EVENT_STATUS_FLAGS_ONE_OUT & ~`MESF_IMPLEMENTED_MASK) == 32'h0)
		else $error("unimplemented bit set");
	AST_STICKY: assert property ((~EVENT_STATUS_FLAGS_ONE_OUT & $past(EVENT_STATUS_FLAGS_ONE_OUT)
		& ~(($past(REG_WR_IN, 2) && $past(hit, 2)) ? $past(REG_WDATA_IN, 2) : 32'h0)) == 32'h0)
		else $error("flag dropped without clear");
	AST_CLEAR: assert property (REG_WR_IN && hit && REG_WDATA_IN[23] && !SAG_CHANGE_IN[0]
		|=> ##1 !EVENT_STATUS_FLAGS_ONE_OUT[23]) else $error("clear ignored");
	AST_SAG: assert property ((|SAG_CHANGE_IN) |-> ##2 ((EVENT_STATUS_FLAGS_ONE_OUT[25:23]
		& $past(SAG_CHANGE_IN, 2)) == $past(SAG_CHANGE_IN, 2))) else $error("dip flag missing");
	AST_OVERCURRENT: assert property ((|OVERCURRENT_PHASE_IN) |=>
		OVERCURRENT_PHASE_REGISTER_OUT == $past(OVERCURRENT_PHASE_IN) ##1 EVENT_STATUS_FLAGS_ONE_OUT[17])
		else $error("overcurrent not recorded");
	// Main scenarios reached
	COV_READ: cover property (REG_RD_IN && hit ##1 REG_RDATA_OUT != 32'h0);
	COV_CLEAR: cover property (REG_WR_IN && hit && REG_WDATA_IN != 32'h0);
	COV_SAG: cover property (|SAG_CHANGE_IN);
endmodule

bind mesf_event_status_flags mesf_props mesf_props_i (.CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN),
	.REG_ADDR_IN(REG_ADDR_IN), .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN), .REG_WDATA_IN(REG_WDATA_IN),
	.REG_RDATA_OUT(REG_RDATA_OUT), .REG_RVALID_OUT(REG_RVALID_OUT), .SAG_CHANGE_IN(SAG_CHANGE_IN),
	.OVERCURRENT_PHASE_IN(OVERCURRENT_PHASE_IN), .OVERCURRENT_PHASE_REGISTER_OUT(OVERCURRENT_PHASE_REGISTER_OUT),
	.EVENT_STATUS_FLAGS_ONE_OUT(EVENT_STATUS_FLAGS_ONE_OUT));
`default_nettype wire

// *** bench/tb_top.sv ***
// Self-checking testbench for the event status flags register
`timescale 1ns/1ns
`default_nettype none
`include "mesf_map.vh"

module tb_top;
	logic        clk = 1'b0;
	logic        rst_n, wr, rd, lpm, rvalid;
	logic [15:0] addr;
	logic [31:0] wdata, ev, cval, rdata, csr, flags, seed, r, w;
	logic [2:0]  ocp, ocr, idr;
	logic [31:0] exp_q[$];
	int          error_cnt = 0;
	int          num_checks = 0;
	localparam logic [15:0] ADDR = `MESF_ADDR_EVENT_STATUS_FLAGS_ONE;

	mesf_event_status_flags mesf_event_status_flags_i (.CORE_CLK_IN(clk), .NRST_IN(rst_n), .REG_ADDR_IN(addr),
		.REG_WR_IN(wr), .REG_RD_IN(rd), .REG_WDATA_IN(wdata), .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid),
		.CHECKSUM_DONE_IN(ev[27]), .CHECKSUM_CHANGED_IN(ev[26]), .CHECKSUM_VALUE_IN(cval),
		.CHECKSUM_RESULT_REGISTER_OUT(csr), .SAG_CHANGE_IN(ev[25:23]), .OVERVOLTAGE_CHANGE_IN(ev[22:20]),
		.PHASE_ORDER_ERROR_IN(ev[18]), .OVERCURRENT_PHASE_IN(ev[17] ? ocp : 3'h0),
		.OVERCURRENT_PHASE_REGISTER_OUT(ocr), .POWERUP_DONE_IN(ev[16]), .LOWEST_POWER_MODE_IN(lpm),
		.CURRENT_CROSSING_IN(ev[15:13]), .COMBINED_CROSSING_IN(ev[12]), .VOLTAGE_CROSSING_IN(ev[11:9]),
		.CROSSING_TIMEOUT_IN(ev[8:6]), .FUND_APPARENT_IDLE_IN({3{ev[5]}}), .IDLE_PHASE_REGISTER_OUT(idr),
		.EVENT_STATUS_FLAGS_ONE_OUT(flags));

	// Clock at 10 MHz
	always #50 clk = ~clk;

	// Xorshift source seeded at 92
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle strobes, held until the sampling edge has passed
	task automatic rd_reg(input logic [15:0] a, input logic [31:0] e);
		addr = a;
		rd = 1'b1;
		exp_q.push_back(e);
		cyc(1);
		rd = 1'b0;
		cyc(1);
	endtask

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask

	task automatic print_verdict();
		if (error_cnt == 0 && num_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Read results compared against the oldest expectation
	always @(negedge clk) begin
		if (rvalid === 1'b1) begin
			if (exp_q.size() == 0) check("spare read", 32'h0, 32'h1);
			else check("read data", rdata, exp_q.pop_front());
		end
	end

	initial begin
		{addr, wr, rd, wdata, ev, lpm, ocp, cval} = '0;
		seed = 32'h0000005C;
		rst_n = 1'b0;
		cyc(16);
		rst_n = 1'b1;
		cyc(2);
		rd_reg(ADDR, 32'h0);
		// Each event alone: set, read, clear, read back zero
		for (int k = 5; k < 28; k++) begin
			cval = rnd();
			ocp = cval[2:0] | 3'h1;
			ev[k] = 1'b1;
			cyc(1);
			if (k == 5) check("idle phases", {29'h0, idr}, 32'h7);
			ev = '0;
			cyc(2);
			check("flag register", flags, (32'h1 << k) & `MESF_IMPLEMENTED_MASK);
			if (k >= 26) check("checksum result", csr, cval);
			if (k == 17) check("overcurrent phases", {29'h0, ocr}, {29'h0, ocp});
			rd_reg(ADDR, (32'h1 << k) & `MESF_IMPLEMENTED_MASK);
			wr_reg(ADDR, 32'h1 << k);
			rd_reg(ADDR, 32'h0);
		end
		// Random event groups, foreign-address writes and partial clears
		for (int i = 0; i < 20; i++) begin
			lpm = 1'b1;
			cyc(1);
			lpm = 1'b0;
			cyc(2);
			r = rnd() & `MESF_IMPLEMENTED_MASK;
			ev = r;
			cyc(1);
			ev = '0;
			cyc(2);
			wr_reg(ADDR + 16'h0001, 32'hFFFFFFFF);
			rd_reg(ADDR + 16'h0001, 32'h0);
			rd_reg(ADDR, r);
			w = rnd();
			wr_reg(ADDR, w);
			rd_reg(ADDR, r & ~w);
			wr_reg(ADDR, 32'hFFFFFFFF);
		end
		for (int t = 0; t < 10 && exp_q.size() != 0; t++) cyc(1);
		if (exp_q.size() != 0) check("pending reads", 32'h0, 32'h1);
		print_verdict();
	end
endmodule
`default_nettype wire
